// *** mhb_pkg.sv ***
/*
  Constants for the multiplexed host bus controller: timing figures in ns,
  derived cycle counts at 200 MHz, command register offsets and modes.
  Assumes a single 200 MHz clock in the controller.
*/
package mhb_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // Least times, rounded up to cycles
  localparam int T_WALE_NS = 10;
  localparam int T_ADRS_NS = 10;
  localparam int T_ADRH_NS = 5;
  localparam int T_ALERD_NS = 5;
  localparam int T_RDWRS_NS = 5;
  localparam int T_RDWRH_NS = 5;
  localparam int T_STRB_NS = 32;
  localparam int T_RECOV_NS = 13;
  localparam int T_RDDV_NS = 30;
  localparam int T_DS_NS = 7;
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int C_WALE = ns2cyc(T_WALE_NS > T_ADRS_NS ? T_WALE_NS
                                                       : T_ADRS_NS);
  localparam int C_ADRH = ns2cyc(T_ADRH_NS);
  localparam int C_ALERD = ns2cyc(T_ALERD_NS);
  localparam int C_RDWRS = ns2cyc(T_RDWRS_NS);
  localparam int C_RDWRH = ns2cyc(T_RDWRH_NS);
  localparam int C_STRB = ns2cyc(T_STRB_NS > T_RDDV_NS ? T_STRB_NS
                                                       : T_RDDV_NS) + 1;
  localparam int C_RECOV = ns2cyc(T_RECOV_NS);
  localparam int C_DS = ns2cyc(T_DS_NS);
  localparam int CNT_W = 4;
  // Command register offsets (word addressed, 4-bit address)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  // Control register bit positions
  localparam int CTL_SCHEME = 0;
  localparam int CTL_LAT_LVL = 1;
  localparam int CTL_SEL_LVL = 2;
  localparam int CTL_RD_LVL = 3;
  localparam int CTL_WR_LVL = 4;
  localparam int CTL_GATE = 5;
  localparam int CTL_DUAL = 6;
  localparam int CTL_BYTE = 7;
  localparam int CTL_HIFIRST = 8;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  // Command register bits
  localparam int CMD_GO = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_NEWADDR = 2;
  typedef enum logic [3:0] {
    MHB_IDLE, MHB_LAT1, MHB_HOLD1, MHB_LAT2, MHB_HOLD2, MHB_GAP,
    MHB_SETUP, MHB_STROBE, MHB_RELEASE, MHB_RECOV
  } mhb_state_type;
endpackage

// *** mhb_host_ctrl.sv ***
/*
  Host-side controller that drives a multiplexed address/data bus port
  through its pins, single or dual phase latching, either strobe scheme.
  Assumes pin inputs are synchronous to ref_clk_i and that software orders
  cycles through the command registers over a plain register port.
*/
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module mhb_host_ctrl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Software register port
  input wire logic [3:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o,
  // Address/data bus
  input wire logic [15:0] ad_i,
  output logic [15:0] ad_o,
  output logic [1:0] ad_oe_o,
  // Control pins
  output logic addr_latch_low_strobe_o,
  output logic addr_latch_high_strobe_o,
  output logic chip_select_o,
  output logic read_dir_o,
  output logic write_transfer_enable_strobe_o
);
  mhb_pkg::mhb_state_type state_q;
  logic [8:0] ctrl_q;
  logic [15:0] addr_q, wdata_q, rdata_q;
  logic [3:0] cnt_q;
  logic pend_q, pend_wr_q, pend_na_q, wrote_last_q, err_q, hi_phase_q;
  logic lat_q, sel_q, rd_q, wr_q;
  logic go;
  assign go = sw_wr_i && sw_addr_i == mhb_pkg::REG_CMD
           && sw_wdata_i[mhb_pkg::CMD_GO];

  // Level mapping: active flag to pin level
  function automatic logic lvl(input logic act, input logic hi);
    return hi ? act : ~act;
  endfunction

  // Configuration and operand registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= mhb_pkg::CTRL_RESET;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
    end else if (sw_wr_i) begin
      // Changing modes mid-cycle would corrupt the pins, so ignore it
      if (sw_addr_i == mhb_pkg::REG_CTRL && state_q == mhb_pkg::MHB_IDLE)
        ctrl_q <= sw_wdata_i[8:0];
      if (sw_addr_i == mhb_pkg::REG_ADDR)
        addr_q <= sw_wdata_i;
      if (sw_addr_i == mhb_pkg::REG_WDATA)
        wdata_q <= sw_wdata_i;
    end
  end

  // Pending command, taken when idle or queued
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
      pend_wr_q <= 1'b0;
      pend_na_q <= 1'b0;
      err_q <= 1'b0;
    end else if (go && !pend_q) begin
      // New address after a write is illegal: refuse and flag it
      if (sw_wdata_i[mhb_pkg::CMD_NEWADDR] && wrote_last_q) begin
        err_q <= 1'b1;
      end else begin
        pend_q <= 1'b1;
        pend_wr_q <= sw_wdata_i[mhb_pkg::CMD_WRITE];
        pend_na_q <= sw_wdata_i[mhb_pkg::CMD_NEWADDR];
        err_q <= 1'b0;
      end
    end else if (state_q == mhb_pkg::MHB_IDLE && pend_q) begin
      pend_q <= 1'b0;
    end
  end

  // Cycle sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q <= mhb_pkg::MHB_IDLE;
      cnt_q <= 4'h0;
      lat_q <= 1'b0;
      sel_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      hi_phase_q <= 1'b0;
      wrote_last_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      unique case (state_q)
        mhb_pkg::MHB_IDLE: begin
          if (pend_q) begin
            sel_q <= 1'b1;
            if (pend_na_q || !wrote_last_q && pend_na_q) begin
              state_q <= mhb_pkg::MHB_LAT1;
              hi_phase_q <= ctrl_q[mhb_pkg::CTL_HIFIRST];
            end else begin
              state_q <= mhb_pkg::MHB_SETUP;
              cnt_q <= 4'(mhb_pkg::C_RDWRS);
            end
          end
        end
        mhb_pkg::MHB_LAT1, mhb_pkg::MHB_LAT2: begin
          // Select already active one cycle earlier, set in idle whatever the gating bit
          lat_q <= 1'b1;
          cnt_q <= 4'(mhb_pkg::C_WALE);
          state_q <= (state_q == mhb_pkg::MHB_LAT1) ? mhb_pkg::MHB_HOLD1
                                                    : mhb_pkg::MHB_HOLD2;
        end
        mhb_pkg::MHB_HOLD1, mhb_pkg::MHB_HOLD2: begin
          if (lat_q && cnt_q == 4'h0) begin
            lat_q <= 1'b0;
            cnt_q <= 4'(mhb_pkg::C_ADRH);
          end else if (!lat_q && cnt_q == 4'h0) begin
            if (state_q == mhb_pkg::MHB_HOLD1
                && ctrl_q[mhb_pkg::CTL_DUAL]) begin
              hi_phase_q <= ~hi_phase_q;
              state_q <= mhb_pkg::MHB_LAT2;
            end else begin
              state_q <= mhb_pkg::MHB_GAP;
              cnt_q <= 4'(mhb_pkg::C_ALERD);
            end
          end
        end
        mhb_pkg::MHB_GAP: begin
          if (cnt_q == 4'h0)
            state_q <= mhb_pkg::MHB_SETUP;
          cnt_q <= (cnt_q == 4'h0) ? 4'(mhb_pkg::C_RDWRS) : cnt_q - 4'h1;
        end
        mhb_pkg::MHB_SETUP: begin
          // Direction settles before enable; read strobe only for reads
          // Separate read strobe rises where a write strobe would
          rd_q <= ctrl_q[mhb_pkg::CTL_SCHEME] ? !pend_wr_q
            : !pend_wr_q && cnt_q == 4'h0;
          if (cnt_q == 4'h0) begin
            wr_q <= ctrl_q[mhb_pkg::CTL_SCHEME] || pend_wr_q;
            state_q <= mhb_pkg::MHB_STROBE;
            // Zero is a cycle too, so load one less than the length
            cnt_q <= 4'(mhb_pkg::C_STRB - 1);
          end
        end
        mhb_pkg::MHB_STROBE: begin
          if (cnt_q == 4'h0) begin
            if (!pend_wr_q)
              rdata_q <= ctrl_q[mhb_pkg::CTL_BYTE] ? {8'h00, ad_i[7:0]}
                                                   : ad_i;
            wr_q <= 1'b0;
            if (!ctrl_q[mhb_pkg::CTL_SCHEME])
              rd_q <= 1'b0;
            wrote_last_q <= pend_wr_q;
            state_q <= mhb_pkg::MHB_RELEASE;
            cnt_q <= 4'(mhb_pkg::C_RDWRH);
          end
        end
        mhb_pkg::MHB_RELEASE: begin
          if (cnt_q == 4'h0) begin
            rd_q <= 1'b0;
            sel_q <= 1'b0;
            state_q <= mhb_pkg::MHB_RECOV;
            cnt_q <= 4'(mhb_pkg::C_RECOV);
          end
        end
        mhb_pkg::MHB_RECOV: begin
          if (cnt_q == 4'h0)
            state_q <= mhb_pkg::MHB_IDLE;
        end
        default: state_q <= mhb_pkg::MHB_IDLE;
      endcase
    end
  end

  // Pin drive, all registered, levels per control bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_latch_low_strobe_o <= 1'b1;
      addr_latch_high_strobe_o <= 1'b1;
      chip_select_o <= 1'b1;
      read_dir_o <= 1'b1;
      write_transfer_enable_strobe_o <= 1'b1;
      ad_o <= 16'h0000;
      ad_oe_o <= 2'b00;
    end else begin
      addr_latch_low_strobe_o <= lvl(lat_q && (!ctrl_q[mhb_pkg::CTL_DUAL]
        || !hi_phase_q), ctrl_q[mhb_pkg::CTL_LAT_LVL]);
      addr_latch_high_strobe_o <= lvl(lat_q && (!ctrl_q[mhb_pkg::CTL_DUAL]
        || hi_phase_q), ctrl_q[mhb_pkg::CTL_LAT_LVL]);
      chip_select_o <= lvl(sel_q, ctrl_q[mhb_pkg::CTL_SEL_LVL]);
      // Direction mode: read_dir high-active means read
      read_dir_o <= lvl(rd_q, ctrl_q[mhb_pkg::CTL_RD_LVL]);
      write_transfer_enable_strobe_o <= lvl(wr_q,
                                            ctrl_q[mhb_pkg::CTL_WR_LVL]);
      unique case (state_q)
        mhb_pkg::MHB_LAT1, mhb_pkg::MHB_HOLD1,
        mhb_pkg::MHB_LAT2, mhb_pkg::MHB_HOLD2: begin
          if (ctrl_q[mhb_pkg::CTL_DUAL]) begin
            ad_o <= {8'h00, hi_phase_q ? addr_q[15:8] : addr_q[7:0]};
            ad_oe_o <= 2'b01;
          end else begin
            ad_o <= addr_q;
            ad_oe_o <= 2'b11;
          end
        end
        mhb_pkg::MHB_SETUP, mhb_pkg::MHB_STROBE: begin
          ad_o <= wdata_q;
          // Upper lane stays off in byte mode; device may hold it
          ad_oe_o <= pend_wr_q ? {!ctrl_q[mhb_pkg::CTL_BYTE], 1'b1}
                               : 2'b00;
        end
        default: begin
          ad_oe_o <= 2'b00;
        end
      endcase
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sw_rdata_o <= 16'h0000;
    end else if (sw_rd_i) begin
      unique case (sw_addr_i)
        mhb_pkg::REG_CTRL: sw_rdata_o <= {7'h00, ctrl_q};
        mhb_pkg::REG_ADDR: sw_rdata_o <= addr_q;
        mhb_pkg::REG_WDATA: sw_rdata_o <= wdata_q;
        mhb_pkg::REG_RDATA: sw_rdata_o <= rdata_q;
        mhb_pkg::REG_STAT: sw_rdata_o <= {12'h000, wrote_last_q, err_q,
          pend_q, state_q != mhb_pkg::MHB_IDLE};
        default: sw_rdata_o <= 16'h0000;
      endcase
    end else begin
      sw_rdata_o <= 16'h0000;
    end
  end
endmodule

// *** mhb_props.sv ***
/*
  Pin checker for the host bus controller, bound to mhb_host_ctrl.
  Assumes CTRL is only written while the bus is idle.
*/
`timescale 1ns/1ps
module mhb_props (
  // Clock, reset, software port
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  // Bus pins
  input wire logic [15:0] ad_o,
  input wire logic [1:0] ad_oe_o,
  input wire logic addr_latch_low_strobe_o,
  input wire logic addr_latch_high_strobe_o,
  input wire logic chip_select_o,
  input wire logic read_dir_o,
  input wire logic write_transfer_enable_strobe_o
);
  logic [8:0] cfg_q;
  logic [8:0] lvl_q;
  logic lo, hi, cs, rd, we, st;
  // Second stage because pins follow CTRL one edge late
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_q <= 9'h000;
      lvl_q <= 9'h000;
    end else begin
      if (sw_wr_i && sw_addr_i == mhb_pkg::REG_CTRL) begin
        cfg_q <= sw_wdata_i[8:0];
      end
      lvl_q <= cfg_q;
    end
  end
  // Pin activity under the programmed levels
  assign lo = addr_latch_low_strobe_o == lvl_q[1];
  assign hi = addr_latch_high_strobe_o == lvl_q[1];
  assign cs = chip_select_o == lvl_q[2];
  assign rd = read_dir_o == lvl_q[3];
  assign we = write_transfer_enable_strobe_o == lvl_q[4];
  assign st = lvl_q[0] ? we : (rd || we);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_strobe_run;
    st [*8] ##1 !st;
  endsequence
  a_latch_sel: assert property ((lo || hi) |-> cs)
    else $error("latch strobe without select");
  a_strobe_sel: assert property (st |-> cs)
    else $error("data strobe without select");
  a_sel_steady: assert property (st && $past(st) |-> $stable(cs))
    else $error("select moved under a strobe");
  a_strobe_len: assert property ($rose(st) |-> s_strobe_run)
    else $error("data strobe not eight cycles");
  a_addr_hold: assert property ($fell(lo) |-> $stable(ad_o) && ad_oe_o[0])
    else $error("address not held past latch");
  a_byte_lane: assert property (lvl_q[7] && st |-> !ad_oe_o[1])
    else $error("upper lane driven in byte mode");
  a_single_pair: assert property (!lvl_q[6] |-> lo == hi)
    else $error("single phase strobes apart");
  a_dual_apart: assert property (lvl_q[6] |-> !(lo && hi))
    else $error("dual phase strobes overlap");
  a_rw_apart: assert property (!lvl_q[0] |-> !(rd && we))
    else $error("read and write strobes together");
  a_dir_steady: assert property (lvl_q[0] && $rose(we) |->
    $stable(read_dir_o) throughout we [*8])
    else $error("direction moved under enable");
endmodule
bind mhb_host_ctrl mhb_props i_props (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
  .sw_wr_i(sw_wr_i), .ad_o(ad_o), .ad_oe_o(ad_oe_o),
  .addr_latch_low_strobe_o(addr_latch_low_strobe_o),
  .addr_latch_high_strobe_o(addr_latch_high_strobe_o),
  .chip_select_o(chip_select_o), .read_dir_o(read_dir_o),
  .write_transfer_enable_strobe_o(write_transfer_enable_strobe_o));

// *** mhb_dev_model.sv ***
/*
  Behavioural model of the bus port device at the pins.
  Assumes straps come from the bench and match the controller's CTRL.
*/
`timescale 1ns/1ps
module mhb_dev_model (
  // Clock and straps
  input wire logic ref_clk_i,
  input wire logic [8:0] strap_i,
  // Pins
  input wire logic [15:0] ad_o,
  input wire logic [1:0] ad_oe_o,
  input wire logic lat_lo_i,
  input wire logic lat_hi_i,
  input wire logic sel_i,
  input wire logic rd_dir_i,
  input wire logic wr_en_i,
  // Device drive and observed state
  output logic [15:0] dev_ad_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  logic lo, hi, cs, rdl, wel, rd, wr, lo_q, hi_q, wr_q;
  logic [15:0] bus, wlast_q;
  logic [15:0] drv_q = 16'h0000;
  assign lo = lat_lo_i == strap_i[1];
  assign hi = lat_hi_i == strap_i[1];
  assign cs = sel_i == strap_i[2];
  assign rdl = rd_dir_i == strap_i[3];
  assign wel = wr_en_i == strap_i[4];
  assign rd = cs && (strap_i[0] ? wel && rdl : rdl);
  assign wr = cs && (strap_i[0] ? wel && !rdl : wel);
  assign bus = {ad_oe_o[1] ? ad_o[15:8] : drv_q[15:8],
    ad_oe_o[0] ? ad_o[7:0] : drv_q[7:0]};
  assign dev_ad_o = drv_q;
  // Capture on release; gating drops latches seen without select
  always_ff @(posedge ref_clk_i) begin
    lo_q <= lo;
    hi_q <= hi;
    wr_q <= wr;
    if (lo_q && !lo && (cs || !strap_i[5])) begin
      addr_o[7:0] <= bus[7:0];
    end
    if (hi_q && !hi && (cs || !strap_i[5])) begin
      addr_o[15:8] <= strap_i[6] ? bus[7:0] : bus[15:8];
    end
    // Controller may drop data with the strobe, so keep the last seen
    if (wr) begin
      wlast_q <= bus;
    end
    if (wr_q && !wr) begin
      wdata_o <= wlast_q;
    end
    // Released lanes toggle so a stale value never reads as good
    drv_q[7:0] <= rd ? addr_o[7:0] ^ 8'h5a : ~drv_q[7:0];
    drv_q[15:8] <= rd && !strap_i[7] ? addr_o[15:8] ^ 8'h5a
      : ~drv_q[15:8];
  end
endmodule

// *** muxed_host_bus_cycle_control_tb.sv ***
/*
  Self-checking bench: software port driver, device model on the pins.
  Assumes the controller clears pending when a cycle starts and busy once recovery ends.
*/
`timescale 1ns/1ps
module muxed_host_bus_cycle_control_tb;
  logic ref_clk_i, rst_n_i, sw_wr_i, sw_rd_i, lo, hi, cs, rdir, wte;
  logic [3:0] sw_addr_i;
  logic [15:0] sw_wdata_i, sw_rdata_o, ad_i, ad_o, dev_addr, dev_wdata;
  logic [1:0] ad_oe_o;
  logic [8:0] cfg;
  int mismatches = 0;
  int check_count = 0;
  mhb_host_ctrl i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
    .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .ad_i(ad_i), .ad_o(ad_o),
    .ad_oe_o(ad_oe_o), .addr_latch_low_strobe_o(lo),
    .addr_latch_high_strobe_o(hi), .chip_select_o(cs), .read_dir_o(rdir),
    .write_transfer_enable_strobe_o(wte));
  mhb_dev_model i_dev (.ref_clk_i(ref_clk_i), .strap_i(cfg), .ad_o(ad_o),
    .ad_oe_o(ad_oe_o), .lat_lo_i(lo), .lat_hi_i(hi), .sel_i(cs),
    .rd_dir_i(rdir), .wr_en_i(wte), .dev_ad_o(ad_i), .addr_o(dev_addr),
    .wdata_o(dev_wdata));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask
  // Issue a command, then poll until neither pending nor busy
  task automatic go(input logic [15:0] c);
    logic [15:0] s;
    sw_write(mhb_pkg::REG_CMD, c);
    s = 16'h0003;
    for (int n = 0; n < 100 && s[1:0] !== 2'b00; n++)
      sw_read(mhb_pkg::REG_STAT, s);
    chk("cycle finished", 16'h0000, s & 16'h0003);
  endtask
  // New address read, write, then read again at the same address
  task automatic xfer(input logic [8:0] c, input logic [15:0] a, w);
    logic [15:0] r, m;
    cfg <= c;
    sw_write(mhb_pkg::REG_CTRL, {7'h00, c});
    sw_write(mhb_pkg::REG_ADDR, a);
    sw_write(mhb_pkg::REG_WDATA, w);
    m = c[7] ? 16'h00ff : 16'hffff;
    go(16'h0005);
    chk("latched address", a, dev_addr);
    sw_read(mhb_pkg::REG_RDATA, r);
    chk("read data", (a ^ 16'h5a5a) & m, r);
    go(16'h0003);
    chk("write data", w & m, dev_wdata & m);
    go(16'h0001);
    sw_read(mhb_pkg::REG_RDATA, r);
    chk("read after write", (a ^ 16'h5a5a) & m, r);
  endtask
  task automatic test_single();
    logic [15:0] s;
    chk("select idle", 16'h0001, {15'h0, cs});
    xfer(9'h000, 16'h1234, 16'hbeef);
    go(16'h0003);
    go(16'h0007);
    sw_read(mhb_pkg::REG_STAT, s);
    chk("address after write", 16'h0004, s & 16'h0004);
    chk("address kept", 16'h1234, dev_addr);
    // A plain read is legal after a write and clears the refusal flag
    go(16'h0001);
    sw_read(mhb_pkg::REG_STAT, s);
    chk("error cleared", 16'h0000, s & 16'h0004);
    $display("test_single done");
  endtask
  task automatic test_dual_dir();
    xfer(9'h17f, 16'hc3a1, 16'h5a0f);
    $display("test_dual_dir done");
  endtask
  task automatic test_dual_byte();
    xfer(9'h0ca, 16'h5e71, 16'h33cc);
    $display("test_dual_byte done");
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Three scenarios need a few thousand cycles at most
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    rst_n_i = 1'b0;
    sw_wr_i = 1'b0;
    sw_rd_i = 1'b0;
    sw_addr_i = 4'h0;
    sw_wdata_i = 16'h0000;
    cfg = 9'h000;
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    test_single();
    test_dual_dir();
    test_dual_byte();
    final_report();
  end
endmodule
